// ---- core/flash_seq_defines.vh ----
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// command codes
`define CMD_READ 8'h00
`define CMD_PROG_SETUP 8'h40
`define CMD_VERIFY_SETUP 8'hC0
`define CMD_RESET 8'hFF
// timing in ns, cycles derived from clock period
`define CLK_PERIOD_NS 20
`define T_PROG_NS 9500
`define T_PROG_CYC ((`T_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WP_NS 60
`define T_WP_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WPH_NS 20
`define T_WPH_CYC ((`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WHGL_NS 6000
`define T_WHGL_CYC ((`T_WHGL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ACC_NS 200
`define T_ACC_CYC ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 10
`endif

// ---- core/flash_prog_host.v ----
// Behaviour
// - write 40h to enter program mode; next write is the operand
// - second write carries target address and data
// - every program is followed by a program-verify sequence
// - write C0h to set up program verify
// - following read returns margin-sensed byte; match means programmed
// - reset is writing FFh on two successive write cycles
// - after reset, write another valid command such as read
// - wait at least 9.5 us after programming start before verify set-up
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.vh"
module flash_prog_host #(
   parameter ADDR_W = 16,
   parameter MAX_TRIES = 25,
   parameter PROG_CYC = `T_PROG_CYC,
   parameter WHGL_CYC = `T_WHGL_CYC
)(
   // clock and reset
   input wire clk,
   input wire rst_n,
   // user request
   input wire prog_req,
   input wire reset_req,
   input wire [ADDR_W-1:0] prog_addr,
   input wire [7:0] prog_data,
   output reg busy,
   output reg done,
   output reg fail,
   // flash pins
   output reg [ADDR_W-1:0] fl_addr,
   output reg [7:0] fl_dq_out,
   output reg fl_dq_oe,
   input wire [7:0] fl_dq_in,
   output reg fl_ce_n,
   output reg fl_oe_n,
   output reg fl_we_n
);
   // ****************************************
   // states
   // ****************************************
   localparam S_IDLE = 4'h0;
   localparam S_WR_LOW = 4'h1;
   localparam S_WR_HIGH = 4'h2;
   localparam S_PROG_WAIT = 4'h3;
   localparam S_VFY_WAIT = 4'h4;
   localparam S_RD = 4'h5;
   localparam S_CHECK = 4'h6;
   localparam S_FINISH = 4'h7;
   // write step indices
   localparam W_SETUP = 3'h0;
   localparam W_OPER = 3'h1;
   localparam W_VFY = 3'h2;
   localparam W_RST1 = 3'h3;
   localparam W_RST2 = 3'h4;
   localparam W_READ = 3'h5;

   reg [3:0] st_r;
   reg [2:0] step_r;
   reg [15:0] cnt_r;
   reg [7:0] tries_r;
   reg [ADDR_W-1:0] addr_r;
   reg [7:0] data_r;
   reg [7:0] dq_s1_r;
   reg [7:0] dq_s2_r;

   // ****************************************
   // pin sync
   // ****************************************
   always @(posedge clk)
   begin
      dq_s1_r <= fl_dq_in;
      dq_s2_r <= dq_s1_r;
   end

   // ****************************************
   // sequencer
   // ****************************************
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= S_IDLE;
         step_r <= W_SETUP;
         cnt_r <= 16'h0000;
         tries_r <= 8'h00;
         addr_r <= {ADDR_W{1'b0}};
         data_r <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         fl_addr <= {ADDR_W{1'b0}};
         fl_dq_out <= 8'h00;
         fl_dq_oe <= 1'b0;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         case (st_r)
            S_IDLE:
            begin
               if (reset_req)
               begin
                  busy <= 1'b1;
                  fail <= 1'b0;
                  step_r <= W_RST1;
                  fl_dq_out <= `CMD_RESET;
                  fl_dq_oe <= 1'b1;
                  fl_ce_n <= 1'b0;
                  fl_we_n <= 1'b0;
                  cnt_r <= 16'h0000;
                  st_r <= S_WR_LOW;
               end
               else if (prog_req)
               begin
                  busy <= 1'b1;
                  fail <= 1'b0;
                  addr_r <= prog_addr;
                  data_r <= prog_data;
                  tries_r <= 8'h00;
                  step_r <= W_SETUP;
                  fl_dq_out <= `CMD_PROG_SETUP;
                  fl_dq_oe <= 1'b1;
                  fl_ce_n <= 1'b0;
                  fl_we_n <= 1'b0;
                  cnt_r <= 16'h0000;
                  st_r <= S_WR_LOW;
               end
            end
            S_WR_LOW:
            begin
               // hold the strobe low for the write pulse width
               if (cnt_r >= `T_WP_CYC - 1)
               begin
                  fl_we_n <= 1'b1;
                  cnt_r <= 16'h0000;
                  st_r <= S_WR_HIGH;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            S_WR_HIGH:
            begin
               // data held past the rising edge, then the next step
               if (cnt_r >= `T_WPH_CYC - 1)
               begin
                  cnt_r <= 16'h0000;
                  fl_ce_n <= 1'b1;
                  fl_dq_oe <= 1'b0;
                  case (step_r)
                     W_SETUP:
                     begin
                        step_r <= W_OPER;
                        fl_addr <= addr_r;
                        fl_dq_out <= data_r;
                        fl_dq_oe <= 1'b1;
                        fl_ce_n <= 1'b0;
                        fl_we_n <= 1'b0;
                        st_r <= S_WR_LOW;
                     end
                     W_OPER: st_r <= S_PROG_WAIT;
                     W_VFY: st_r <= S_VFY_WAIT;
                     W_RST1:
                     begin
                        step_r <= W_RST2;
                        fl_dq_oe <= 1'b1;
                        fl_ce_n <= 1'b0;
                        fl_we_n <= 1'b0;
                        st_r <= S_WR_LOW;
                     end
                     W_RST2:
                     begin
                        step_r <= W_READ;
                        fl_dq_out <= `CMD_READ;
                        fl_dq_oe <= 1'b1;
                        fl_ce_n <= 1'b0;
                        fl_we_n <= 1'b0;
                        st_r <= S_WR_LOW;
                     end
                     default: st_r <= S_FINISH;
                  endcase
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            S_PROG_WAIT:
            begin
               // counted from the operand strobe rising edge
               if (cnt_r >= PROG_CYC - 1)
               begin
                  cnt_r <= 16'h0000;
                  step_r <= W_VFY;
                  fl_dq_out <= `CMD_VERIFY_SETUP;
                  fl_dq_oe <= 1'b1;
                  fl_ce_n <= 1'b0;
                  fl_we_n <= 1'b0;
                  st_r <= S_WR_LOW;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            S_VFY_WAIT:
            begin
               // write-high to output-enable-low recovery
               if (cnt_r >= WHGL_CYC - 1)
               begin
                  cnt_r <= 16'h0000;
                  fl_ce_n <= 1'b0;
                  fl_oe_n <= 1'b0;
                  st_r <= S_RD;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            S_RD:
            begin
               // extra cycles cover the two-stage input sync
               if (cnt_r >= `T_ACC_CYC + 1)
               begin
                  cnt_r <= 16'h0000;
                  st_r <= S_CHECK;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            S_CHECK:
            begin
               fl_oe_n <= 1'b1;
               fl_ce_n <= 1'b1;
               if (dq_s2_r == data_r)
                  st_r <= S_FINISH;
               else if (tries_r >= MAX_TRIES - 1)
               begin
                  fail <= 1'b1;
                  st_r <= S_FINISH;
               end
               else
               begin
                  // bounded retry so a dead byte cannot hang the host
                  tries_r <= tries_r + 8'h01;
                  step_r <= W_SETUP;
                  fl_dq_out <= `CMD_PROG_SETUP;
                  fl_dq_oe <= 1'b1;
                  fl_ce_n <= 1'b0;
                  fl_we_n <= 1'b0;
                  st_r <= S_WR_LOW;
               end
            end
            S_FINISH:
            begin
               busy <= 1'b0;
               done <= 1'b1;
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // flash_prog_host
`default_nettype wire

// ---- verif/flash_seq_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// strobe and timing checks
// ****************
module flash_seq_sva #(parameter PROG_CYC = 8, parameter WHGL_CYC = 4) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // status and flash pins
   input wire busy,
   input wire done,
   input wire [15:0] fl_addr,
   input wire [7:0] fl_dq_out,
   input wire fl_dq_oe,
   input wire fl_ce_n,
   input wire fl_oe_n,
   input wire fl_we_n
);
   reg [9:0] gap_r;
   // cycles since the last write strobe release, saturating so it never wraps
   always @(posedge clk)
      if (!rst_n || $rose(fl_we_n)) gap_r <= 10'h000;
      else if (gap_r != 10'h3FF) gap_r <= gap_r + 10'h001;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_RST_IDLE: assert property ($rose(rst_n) |-> fl_we_n && fl_oe_n && !busy && !done)
      else $error("strobes not idle after reset");
   AST_WE_PULSE: assert property ($fell(fl_we_n) |-> (!fl_we_n) [*3] ##1 fl_we_n)
      else $error("write pulse length wrong");
   AST_WE_CE: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n)
      else $error("write without select or data");
   AST_ADDR_HOLD: assert property (!fl_we_n && !$fell(fl_we_n) |-> $stable(fl_addr))
      else $error("address moved during write");
   AST_READ_EXCL: assert property (!fl_oe_n |-> !fl_ce_n && !fl_dq_oe)
      else $error("bus driven during read");
   AST_VERIFY_WAIT: assert property ($rose(fl_we_n) && fl_dq_out == 8'hC0 |-> gap_r >= PROG_CYC)
      else $error("verify set-up too early");
   AST_READ_WAIT: assert property ($fell(fl_oe_n) |-> gap_r >= WHGL_CYC)
      else $error("read too soon after write");
   // a request held high across done may legally restart busy the next cycle
   AST_DONE_PULSE: assert property (done |-> !busy ##1 !done)
      else $error("done not a single pulse");
endmodule // flash_seq_sva
bind flash_prog_host flash_seq_sva #(.PROG_CYC(PROG_CYC), .WHGL_CYC(WHGL_CYC)) u_flash_seq_sva (
   .clk(clk), .rst_n(rst_n), .busy(busy), .done(done), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
   .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
`default_nettype wire

// ---- verif/flash_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// command register device
// ****************
module flash_dev_model #(parameter T_PROG_NS = 160) (
   input wire [15:0] fl_addr,
   input wire [7:0] dq_in,
   output wire [7:0] dq_out,
   input wire ce_n,
   input wire oe_n,
   input wire we_n
);
   reg [7:0] mem [0:65535];
   reg [15:0] lat_r = 16'h0000;
   reg [1:0] mode_r = 2'h0;
   reg ff_r = 1'b0;
   reg pend_r = 1'b0;
   reg [7:0] cmd_r = 8'hFF;
   integer bad = 0, viol = 0, i;
   realtime t0 = 0.0;
   wire [7:0] v = (bad > 0) ? ~mem[lat_r] : mem[lat_r];
   initial for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hFF;
   always @(posedge we_n) if (!ce_n)
   begin
      if (mode_r == 2'h1)
      begin
         mem[fl_addr] = mem[fl_addr] & dq_in;
         lat_r = fl_addr;
         t0 = $realtime;
         pend_r = 1'b1;
         mode_r = 2'h0;
      end
      else
      begin
         cmd_r = dq_in;
         if (dq_in == 8'h40) mode_r = 2'h1;
         if (dq_in == 8'h40 && pend_r) viol = viol + 1;
         if (dq_in == 8'hC0 && $realtime - t0 < T_PROG_NS) viol = viol + 1;
         if (dq_in == 8'hC0) {pend_r, mode_r} = 3'h2;
         if (dq_in == 8'hFF && ff_r) mode_r = 2'h0;
         ff_r = (dq_in == 8'hFF) && !ff_r;
      end
   end
   // a released bus shows the inverse so a stale value cannot pass
   assign dq_out = (!ce_n && !oe_n) ? v : ~v;
   always @(posedge oe_n) if (bad > 0) bad = bad - 1;
endmodule // flash_dev_model
`default_nettype wire

// ---- verif/flash_prog_verify_reset_cmd_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// program, retry and reset scenarios
// ****************
module flash_prog_verify_reset_cmd_test;
   reg clk, rst_n, prog_req, reset_req;
   reg [15:0] prog_addr;
   reg [7:0] prog_data;
   reg [31:0] r;
   reg [24:0] q [$];
   reg [24:0] nt;
   wire busy, done, fail, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
   wire [15:0] fl_addr;
   wire [7:0] fl_dq_out, dev_dq, bus;
   integer error_cnt, n_compared, cyc, i;
   assign bus = fl_dq_oe ? fl_dq_out : dev_dq;
   flash_prog_host #(.PROG_CYC(8), .WHGL_CYC(4), .MAX_TRIES(3)) u_flash_prog_host (
      .clk(clk), .rst_n(rst_n), .prog_req(prog_req), .reset_req(reset_req),
      .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .done(done), .fail(fail),
      .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(bus),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
   flash_dev_model #(.T_PROG_NS(160)) u_flash_dev_model (.fl_addr(fl_addr), .dq_in(bus),
      .dq_out(dev_dq), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task conclude;
   begin
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task chk(input [24:0] got, input [24:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task op(input rs, input [15:0] a, input [7:0] d, input f, input integer nbad);
      integer k;
   begin
      u_flash_dev_model.bad = nbad;
      q.push_back({f, a, d});
      @(posedge clk);
      {prog_req, reset_req, prog_addr, prog_data} <= {!rs, rs, a, d};
      k = 0;
      do begin @(posedge clk); #1 k = k + 1; end while (busy !== 1'b1 && k < 50);
      @(posedge clk);
      {prog_req, reset_req} <= 2'b00;
      do begin @(posedge clk); #1 k = k + 1; end while (busy !== 1'b0 && k < 3000);
   end
   endtask
   // oldest note is compared against status and the array byte on each done
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000) begin error_cnt = error_cnt + 1; conclude; end
      if (done === 1'b1)
      begin
         nt = (q.size() > 0) ? q.pop_front() : 25'h1FFFFFF;
         chk({fail, nt[23:8], u_flash_dev_model.mem[nt[23:8]]}, nt);
      end
   end
   initial
   begin
      {rst_n, prog_req, reset_req, prog_addr, prog_data} = 27'h0;
      {error_cnt, n_compared, cyc} = 0;
      r = $urandom(32'h0cf42c63);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
      begin
         r = $urandom;
         op(0, {i[3:0], r[11:0]}, r[23:16], 0, 0);
      end
      op(0, 16'h7000, 8'h5A, 0, 2);
      op(0, 16'h8000, 8'hA5, 1, 3);
      op(1, 16'h7000, 8'h5A, 0, 0);
      chk({17'h0, u_flash_dev_model.cmd_r}, 25'h0);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      op(0, 16'h9001, 8'h3C, 0, 1);
      // the monitor takes the last done one edge after busy falls
      repeat (2) @(posedge clk);
      chk(u_flash_dev_model.viol[24:0], 25'h0);
      chk({24'h0, q.size() == 0}, 25'h1);
      conclude;
   end
endmodule // flash_prog_verify_reset_cmd_test
`default_nettype wire
